// ===== core/rlv_pkg.sv
// Behaviour
// R1 - Displayed level steps 50..100% from actual level in bands of sixteen, except the top band 80..100.
// R2 - Raise and lower lamps follow the raise and lower outputs exactly.
// R3 - Prelube entry closes the valve for preset seconds, 0..100, default 50.
// R4 - Ramp duration accepts 3 to 15 minutes, default 8 minutes.
// R5 - After 3 minutes run, low level ramps target linearly up to setpoint.
// R6 - Zone 1 parameters apply while level error is at most 9%.
// R7 - Error above 9% switches to zone 2 parameters immediately.
// R8 - Zone 2 to zone 1 needs 60 continuous seconds at or below 9%.
// R9 - Zone state reports zone 1, zone 2, transition, or off when stopped.
// R10 - Transition exposes seconds left in the 60 second qualification.
// R11 - Manual raise, lower, hold keys enter manual mode and command the valve.
// R12 - Auto key returns level control to automatic mode.
// R13 - Status shows whether level control is manual or automatic.
// R14 - In proportional band, level change compared with open or close limit.
// R15 - Per period, level change compared with open or close rate limit.
// R16 - Run time splits into control periods; decisions made once per period.
// R17 - Lower drives the valve open, raise drives it closed.
// R18 - Raise and lower never both active; hold releases both.
// R19 - All timers run from a one-second tick and clear on reset.
package rlv_pkg;
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned SEC_NS = 1_000_000_000;
	localparam int unsigned TICK_CYCLES = SEC_NS / CLK_PERIOD_NS;
	localparam int unsigned SEC_PER_MIN = 60;
	localparam int unsigned BYPASS_MIN = 3;
	localparam logic [7:0] BYPASS_S = 8'(BYPASS_MIN * SEC_PER_MIN);
	localparam int unsigned LVL_W = 7;
	localparam int unsigned ADDR_W = 8;
	localparam logic [6:0] LVL_MAX = 7'h64;
	// Zone error limit 9 %, qualification 60 s
	localparam logic [6:0] ZONE_ERR_MAX = 7'h09;
	localparam logic [7:0] ZONE_QUAL_S = 8'h3c;
	localparam logic [6:0] PRESET_MAX = 7'h64;
	localparam logic [6:0] PRESET_DEF = 7'h32;
	localparam logic [3:0] RAMP_LO = 4'h3;
	localparam logic [3:0] RAMP_DEF = 4'h8;
	localparam logic [6:0] SETPT_DEF = 7'h32;
	localparam logic [15:0] PERIOD_DEF = 16'h050a;
	localparam logic [23:0] PLIM_DEF = 24'h0a0202;
	localparam logic [31:0] RLIM_DEF = 32'h04040202;
	// Display band tops and shown values
	localparam logic [6:0] DB0 = 7'h0f;
	localparam logic [6:0] DB1 = 7'h1f;
	localparam logic [6:0] DB2 = 7'h2f;
	localparam logic [6:0] DB3 = 7'h3f;
	localparam logic [6:0] DB4 = 7'h4f;
	localparam logic [6:0] DV0 = 7'h32;
	localparam logic [6:0] DV1 = 7'h3c;
	localparam logic [6:0] DV2 = 7'h46;
	localparam logic [6:0] DV3 = 7'h50;
	localparam logic [6:0] DV4 = 7'h5a;
	localparam logic [6:0] DV5 = 7'h64;
	// Register byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_SETPT = 8'h04;
	localparam logic [7:0] A_PRESET = 8'h08;
	localparam logic [7:0] A_RAMP = 8'h0c;
	localparam logic [7:0] A_PERIOD = 8'h10;
	localparam logic [7:0] A_PLIM = 8'h14;
	localparam logic [7:0] A_RLIM = 8'h18;
	localparam logic [7:0] A_KEY = 8'h1c;
	localparam logic [7:0] A_STATUS = 8'h20;
	// Field positions
	localparam int unsigned CTRL_PRELUBE = 0;
	localparam int unsigned CTRL_RUN = 1;
	localparam int unsigned KEY_RAISE = 0;
	localparam int unsigned KEY_LOWER = 1;
	localparam int unsigned KEY_HOLD = 2;
	localparam int unsigned KEY_AUTO = 3;
	localparam int unsigned ST_MAN = 0;
	localparam int unsigned ST_RAISE = 1;
	localparam int unsigned ST_LOWER = 2;
	localparam int unsigned ST_PRESET = 3;
	localparam int unsigned ST_ZONE = 4;
	localparam int unsigned ST_RAMP = 6;
	localparam int unsigned ST_REM = 8;
	localparam int unsigned ST_TGT = 16;
	localparam int unsigned ST_DISP = 24;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		CMD_HOLD = 2'b00,
		CMD_RAISE = 2'b01,
		CMD_LOWER = 2'b10
	} rlv_cmd_e;
	typedef enum logic [1:0] {
		ZN_OFF = 2'b00,
		ZN_ONE = 2'b01,
		ZN_TWO = 2'b10,
		ZN_TWO_ONE = 2'b11
	} rlv_zone_e;
endpackage

// ===== core/rlv_sec_tick.sv
module rlv_sec_tick #(
	parameter int unsigned CYCLES = 50
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// One-cycle pulse per second
	output logic tick_out
);
	import rlv_pkg::*;
	localparam int unsigned CW = $clog2(CYCLES);
	logic [CW-1:0] cnt_ff;

	if (CYCLES < 2) begin : g_bad
		$error("rlv_sec_tick needs CYCLES of at least 2");
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt_ff <= '0;
			tick_out <= 1'b0;
		end else if (cnt_ff == CW'(CYCLES - 1)) begin
			cnt_ff <= '0;
			tick_out <= 1'b1; // R19
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
			tick_out <= 1'b0;
		end
	end
endmodule

// ===== core/rlv_level_disp.sv
module rlv_level_disp
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Actual and shown level, percent
	input wire logic [rlv_pkg::LVL_W-1:0] level_in,
	output logic [rlv_pkg::LVL_W-1:0] disp_out
);
	import rlv_pkg::*;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			disp_out <= DV0;
		end else if (level_in <= DB0) begin
			disp_out <= DV0; // R1
		end else if (level_in <= DB1) begin
			disp_out <= DV1;
		end else if (level_in <= DB2) begin
			disp_out <= DV2;
		end else if (level_in <= DB3) begin
			disp_out <= DV3;
		end else if (level_in <= DB4) begin
			disp_out <= DV4;
		end else begin
			disp_out <= DV5;
		end
	end
endmodule

// ===== core/rlv_top.sv
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
module rlv_top #(
	parameter int unsigned TICK_CYC = rlv_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic CLK_SYS_IN,
	input wire logic SYS_RST_IN,
	// AXI4-Lite write
	input wire logic [rlv_pkg::ADDR_W-1:0] AWADDR_IN,
	input wire logic AWVALID_IN,
	output logic AWREADY_OUT,
	input wire logic [31:0] WDATA_IN,
	input wire logic [3:0] WSTRB_IN,
	input wire logic WVALID_IN,
	output logic WREADY_OUT,
	output logic [1:0] BRESP_OUT,
	output logic BVALID_OUT,
	input wire logic BREADY_IN,
	// AXI4-Lite read
	input wire logic [rlv_pkg::ADDR_W-1:0] ARADDR_IN,
	input wire logic ARVALID_IN,
	output logic ARREADY_OUT,
	output logic [31:0] RDATA_OUT,
	output logic [1:0] RRESP_OUT,
	output logic RVALID_OUT,
	input wire logic RREADY_IN,
	// Level sensor, percent
	input wire logic [rlv_pkg::LVL_W-1:0] LEVEL_IN,
	// Valve actuator
	output logic RAISE_OUT,
	output logic LOWER_OUT,
	// Panel indications
	output logic RAISE_LED_OUT,
	output logic LOWER_LED_OUT,
	output logic MANUAL_OUT,
	output logic [1:0] ZONE_OUT,
	output logic [7:0] ZONE_REM_OUT,
	output logic [rlv_pkg::LVL_W-1:0] DISP_LEVEL_OUT
);
	import rlv_pkg::*;

	if (TICK_CYC < 2) begin : g_bad
		$error("rlv_top needs TICK_CYC of at least 2");
	end

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [6:0] abs_diff(input logic [6:0] a,
		input logic [6:0] b);
		return (a > b) ? a - b : b - a;
	endfunction

	function automatic logic [7:0] word_of(input logic [7:0] a);
		return {a[7:2], 2'b00};
	endfunction

	// Bus state
	logic awready_ff, wready_ff, arready_ff;
	logic [7:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic wr_en, wr_hit;
	logic [31:0] rd_data;
	logic rd_hit;
	// Programmed values
	logic [1:0] ctrl_ff;
	logic [6:0] setpt_ff, preset_ff;
	logic [3:0] ramp_ff;
	logic [15:0] period_ff;
	logic [23:0] plim_ff;
	logic [31:0] rlim_ff;
	// Control state
	logic tick;
	logic prelube_d_ff;
	logic [6:0] preset_cnt_ff;
	logic [7:0] run_s_ff;
	logic ramp_on_ff;
	logic [6:0] ramp_tgt_ff, ramp_step_ff;
	logic [9:0] ramp_tot_ff, ramp_el_ff, ramp_acc_ff, nxt_acc;
	logic [6:0] target, err, lvl_prev_ff, drop, rise;
	logic over, per_end, run;
	logic [7:0] per_cnt_ff, per_len;
	rlv_zone_e zone_ff;
	logic [7:0] rem_ff;
	rlv_cmd_e auto_cmd_ff, man_cmd_ff, nxt_cmd;
	logic manual_ff;
	logic [31:0] merged;
	logic [6:0] disp;

	rlv_sec_tick #(
		.CYCLES(TICK_CYC)
	) u_tick (
		.clk_in(CLK_SYS_IN),
		.rst_in(SYS_RST_IN),
		.tick_out(tick)
	);

	rlv_level_disp u_disp (
		.clk_in(CLK_SYS_IN),
		.rst_in(SYS_RST_IN),
		.level_in(LEVEL_IN),
		.disp_out(disp)
	);

	assign DISP_LEVEL_OUT = disp;
	assign run = ctrl_ff[CTRL_RUN];

	// Write fires once both halves are held and no response is pending
	assign wr_en = !awready_ff && !wready_ff && !BVALID_OUT;
	assign merged = merge(32'h0, w_data_ff, w_strb_ff);

	always_comb begin
		wr_hit = 1'b1;
		if (word_of(aw_addr_ff) == A_CTRL) begin
			wr_hit = 1'b1;
		end else if (word_of(aw_addr_ff) == A_SETPT) begin
			wr_hit = 1'b1;
		end else if (word_of(aw_addr_ff) == A_PRESET) begin
			wr_hit = 1'b1;
		end else if (word_of(aw_addr_ff) == A_RAMP) begin
			wr_hit = 1'b1;
		end else if (word_of(aw_addr_ff) == A_PERIOD) begin
			wr_hit = 1'b1;
		end else if (word_of(aw_addr_ff) == A_PLIM) begin
			wr_hit = 1'b1;
		end else if (word_of(aw_addr_ff) == A_RLIM) begin
			wr_hit = 1'b1;
		end else if (word_of(aw_addr_ff) == A_KEY) begin
			wr_hit = 1'b1;
		end else begin
			wr_hit = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			aw_addr_ff <= '0;
			w_data_ff <= '0;
			w_strb_ff <= '0;
			BVALID_OUT <= 1'b0;
			BRESP_OUT <= RESP_OKAY;
		end else begin
			if (AWVALID_IN && awready_ff) begin
				awready_ff <= 1'b0;
				aw_addr_ff <= AWADDR_IN;
			end
			if (WVALID_IN && wready_ff) begin
				wready_ff <= 1'b0;
				w_data_ff <= WDATA_IN;
				w_strb_ff <= WSTRB_IN;
			end
			if (wr_en) begin
				BVALID_OUT <= 1'b1;
				BRESP_OUT <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (BVALID_OUT && BREADY_IN) begin
				BVALID_OUT <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff <= 1'b1;
			end
		end
	end

	assign AWREADY_OUT = awready_ff;
	assign WREADY_OUT = wready_ff;

	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			ctrl_ff <= '0;
			setpt_ff <= SETPT_DEF;
			preset_ff <= PRESET_DEF;
			ramp_ff <= RAMP_DEF;
			period_ff <= PERIOD_DEF;
			plim_ff <= PLIM_DEF;
			rlim_ff <= RLIM_DEF;
		end else if (wr_en) begin
			if (word_of(aw_addr_ff) == A_CTRL) begin
				ctrl_ff <= 2'(merge({30'h0, ctrl_ff}, w_data_ff,
					w_strb_ff));
			end else if (word_of(aw_addr_ff) == A_SETPT) begin
				setpt_ff <= (merged[6:0] > LVL_MAX || |merged[31:7]) ?
					LVL_MAX : merged[6:0];
			end else if (word_of(aw_addr_ff) == A_PRESET) begin
				preset_ff <= (merged[6:0] > PRESET_MAX ||
					|merged[31:7]) ? PRESET_MAX : merged[6:0]; // R3
			end else if (word_of(aw_addr_ff) == A_RAMP) begin
				if (|merged[31:4]) begin
					ramp_ff <= 4'hf; // R4
				end else if (merged[3:0] < RAMP_LO) begin
					ramp_ff <= RAMP_LO; // R4
				end else begin
					ramp_ff <= merged[3:0];
				end
			end else if (word_of(aw_addr_ff) == A_PERIOD) begin
				period_ff <= 16'(merge({16'h0, period_ff}, w_data_ff,
					w_strb_ff));
			end else if (word_of(aw_addr_ff) == A_PLIM) begin
				plim_ff <= 24'(merge({8'h0, plim_ff}, w_data_ff,
					w_strb_ff));
			end else if (word_of(aw_addr_ff) == A_RLIM) begin
				rlim_ff <= merge(rlim_ff, w_data_ff, w_strb_ff);
			end
		end
	end

	always_comb begin
		rd_data = '0;
		rd_hit = 1'b1;
		if (word_of(ARADDR_IN) == A_CTRL) begin
			rd_data[1:0] = ctrl_ff;
		end else if (word_of(ARADDR_IN) == A_SETPT) begin
			rd_data[6:0] = setpt_ff;
		end else if (word_of(ARADDR_IN) == A_PRESET) begin
			rd_data[6:0] = preset_ff;
		end else if (word_of(ARADDR_IN) == A_RAMP) begin
			rd_data[3:0] = ramp_ff;
		end else if (word_of(ARADDR_IN) == A_PERIOD) begin
			rd_data[15:0] = period_ff;
		end else if (word_of(ARADDR_IN) == A_PLIM) begin
			rd_data[23:0] = plim_ff;
		end else if (word_of(ARADDR_IN) == A_RLIM) begin
			rd_data = rlim_ff;
		end else if (word_of(ARADDR_IN) == A_KEY) begin
			rd_data = '0;
		end else if (word_of(ARADDR_IN) == A_STATUS) begin
			rd_data[ST_MAN] = manual_ff; // R13
			rd_data[ST_RAISE] = RAISE_OUT;
			rd_data[ST_LOWER] = LOWER_OUT;
			rd_data[ST_PRESET] = |preset_cnt_ff;
			rd_data[ST_ZONE +: 2] = zone_ff;
			rd_data[ST_RAMP] = ramp_on_ff;
			rd_data[ST_REM +: 8] = rem_ff;
			rd_data[ST_TGT +: 7] = target;
			rd_data[ST_DISP +: 7] = disp;
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			arready_ff <= 1'b1;
			RVALID_OUT <= 1'b0;
			RDATA_OUT <= '0;
			RRESP_OUT <= RESP_OKAY;
		end else if (ARVALID_IN && arready_ff) begin
			arready_ff <= 1'b0;
			RVALID_OUT <= 1'b1;
			RDATA_OUT <= rd_data;
			RRESP_OUT <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (RVALID_OUT && RREADY_IN) begin
			arready_ff <= 1'b1;
			RVALID_OUT <= 1'b0;
		end
	end

	assign ARREADY_OUT = arready_ff;

	// Valve preset pulse, started by the rising edge of prelube
	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			prelube_d_ff <= 1'b0;
			preset_cnt_ff <= '0;
		end else begin
			prelube_d_ff <= ctrl_ff[CTRL_PRELUBE];
			if (ctrl_ff[CTRL_PRELUBE] && !prelube_d_ff) begin
				preset_cnt_ff <= preset_ff; // R3
			end else if (tick && |preset_cnt_ff) begin
				preset_cnt_ff <= preset_cnt_ff - 7'h01; // R19
			end
		end
	end

	// Run time, saturating at the start bypass
	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN || !run) begin
			run_s_ff <= '0;
		end else if (tick && run_s_ff != BYPASS_S) begin
			run_s_ff <= run_s_ff + 8'h01;
		end
	end

	// Ramp steps one percent whenever the error accumulator wraps
	assign nxt_acc = ramp_acc_ff + {3'h0, ramp_step_ff};

	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN || !run) begin
			ramp_on_ff <= 1'b0;
			ramp_tgt_ff <= '0;
			ramp_step_ff <= '0;
			ramp_tot_ff <= '0;
			ramp_el_ff <= '0;
			ramp_acc_ff <= '0;
		end else if (tick && run_s_ff == BYPASS_S - 8'h01) begin
			if (LEVEL_IN < setpt_ff) begin
				ramp_on_ff <= 1'b1; // R5
				ramp_tgt_ff <= LEVEL_IN;
				ramp_step_ff <= setpt_ff - LEVEL_IN;
				ramp_tot_ff <= 10'(ramp_ff * SEC_PER_MIN);
				ramp_el_ff <= '0;
				ramp_acc_ff <= '0;
			end
		end else if (tick && ramp_on_ff) begin
			ramp_el_ff <= ramp_el_ff + 10'h001;
			if (ramp_el_ff + 10'h001 == ramp_tot_ff) begin
				ramp_on_ff <= 1'b0;
			end
			if (nxt_acc >= ramp_tot_ff) begin
				ramp_acc_ff <= nxt_acc - ramp_tot_ff;
				ramp_tgt_ff <= ramp_tgt_ff + 7'h01; // R5
			end else begin
				ramp_acc_ff <= nxt_acc;
			end
		end
	end

	assign target = (ramp_on_ff && ramp_tgt_ff < setpt_ff) ?
		ramp_tgt_ff : setpt_ff;
	assign err = abs_diff(LEVEL_IN, target);
	assign over = err > ZONE_ERR_MAX; // R6 R7

	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN || !run) begin
			zone_ff <= ZN_OFF; // R9
			rem_ff <= '0;
		end else begin
			case (zone_ff)
				ZN_OFF: begin
					zone_ff <= over ? ZN_TWO : ZN_ONE;
				end
				ZN_ONE: begin
					if (over) begin
						zone_ff <= ZN_TWO; // R7
					end
				end
				ZN_TWO: begin
					if (!over) begin
						zone_ff <= ZN_TWO_ONE; // R8
						rem_ff <= ZONE_QUAL_S; // R10
					end
				end
				ZN_TWO_ONE: begin
					if (over) begin
						zone_ff <= ZN_TWO; // R8
						rem_ff <= '0;
					end else if (tick) begin
						if (rem_ff == 8'h01) begin
							zone_ff <= ZN_ONE; // R6
						end
						rem_ff <= rem_ff - 8'h01; // R10
					end
				end
				default: begin
					zone_ff <= ZN_OFF;
				end
			endcase
		end
	end

	// Transition still runs on zone 2 settings until qualified
	assign per_len = (zone_ff == ZN_ONE) ? period_ff[7:0] : period_ff[15:8];
	assign per_end = tick && (per_cnt_ff + 8'h01 >= per_len);

	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN || !run) begin
			per_cnt_ff <= '0;
		end else if (per_end) begin
			per_cnt_ff <= '0; // R16
		end else if (tick) begin
			per_cnt_ff <= per_cnt_ff + 8'h01;
		end
	end

	assign drop = (lvl_prev_ff > LEVEL_IN) ? lvl_prev_ff - LEVEL_IN : '0;
	assign rise = (LEVEL_IN > lvl_prev_ff) ? LEVEL_IN - lvl_prev_ff : '0;

	// Open further only while the level is falling too slowly
	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN || !run) begin
			auto_cmd_ff <= CMD_HOLD;
			lvl_prev_ff <= LEVEL_IN;
		end else if (per_end) begin
			lvl_prev_ff <= LEVEL_IN; // R16
			if (LEVEL_IN > target && err <= plim_ff[23:16]) begin
				auto_cmd_ff <= ({1'b0, drop} < plim_ff[7:0]) ?
					CMD_LOWER : CMD_HOLD; // R14 R17
			end else if (LEVEL_IN < target && err <= plim_ff[23:16]) begin
				auto_cmd_ff <= ({1'b0, rise} < plim_ff[15:8]) ?
					CMD_RAISE : CMD_HOLD; // R14 R17
			end else if (LEVEL_IN > target) begin
				auto_cmd_ff <= ({1'b0, drop} < ((zone_ff == ZN_ONE) ?
					rlim_ff[7:0] : rlim_ff[23:16])) ?
					CMD_LOWER : CMD_HOLD; // R15
			end else if (LEVEL_IN < target) begin
				auto_cmd_ff <= ({1'b0, rise} < ((zone_ff == ZN_ONE) ?
					rlim_ff[15:8] : rlim_ff[31:24])) ?
					CMD_RAISE : CMD_HOLD; // R15
			end else begin
				auto_cmd_ff <= CMD_HOLD;
			end
		end
	end

	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			manual_ff <= 1'b0;
			man_cmd_ff <= CMD_HOLD;
		end else if (wr_en && word_of(aw_addr_ff) == A_KEY) begin
			if (merged[KEY_AUTO]) begin
				manual_ff <= 1'b0; // R12
			end else if (merged[KEY_HOLD]) begin
				manual_ff <= 1'b1; // R11
				man_cmd_ff <= CMD_HOLD;
			end else if (merged[KEY_RAISE]) begin
				manual_ff <= 1'b1; // R11
				man_cmd_ff <= CMD_RAISE;
			end else if (merged[KEY_LOWER]) begin
				manual_ff <= 1'b1; // R11
				man_cmd_ff <= CMD_LOWER;
			end
		end
	end

	always_comb begin
		if (manual_ff) begin
			nxt_cmd = man_cmd_ff;
		end else if (|preset_cnt_ff) begin
			nxt_cmd = CMD_RAISE; // R3 R17
		end else if (run) begin
			nxt_cmd = auto_cmd_ff;
		end else begin
			nxt_cmd = CMD_HOLD;
		end
	end

	// Single command value keeps the pair exclusive
	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			RAISE_OUT <= 1'b0;
			LOWER_OUT <= 1'b0;
			RAISE_LED_OUT <= 1'b0;
			LOWER_LED_OUT <= 1'b0;
			MANUAL_OUT <= 1'b0;
			ZONE_OUT <= ZN_OFF;
			ZONE_REM_OUT <= '0;
		end else begin
			RAISE_OUT <= nxt_cmd == CMD_RAISE; // R18
			LOWER_OUT <= nxt_cmd == CMD_LOWER; // R18
			RAISE_LED_OUT <= nxt_cmd == CMD_RAISE; // R2
			LOWER_LED_OUT <= nxt_cmd == CMD_LOWER; // R2
			MANUAL_OUT <= manual_ff; // R13
			ZONE_OUT <= zone_ff; // R9
			ZONE_REM_OUT <= rem_ff; // R10
		end
	end
endmodule

// ===== verification/rlv_top_asserts.sv
module rlv_top_asserts #(
	parameter int unsigned TICK_CYC = 50
) (
	// Clock and reset
	input wire logic CLK_SYS_IN,
	input wire logic SYS_RST_IN,
	// Bus handshakes
	input wire logic AWVALID_IN,
	input wire logic AWREADY_OUT,
	input wire logic WVALID_IN,
	input wire logic WREADY_OUT,
	input wire logic BVALID_OUT,
	input wire logic ARVALID_IN,
	input wire logic ARREADY_OUT,
	input wire logic RVALID_OUT,
	// Level, valve and panel
	input wire logic [rlv_pkg::LVL_W-1:0] LEVEL_IN,
	input wire logic RAISE_OUT,
	input wire logic LOWER_OUT,
	input wire logic RAISE_LED_OUT,
	input wire logic LOWER_LED_OUT,
	input wire logic [1:0] ZONE_OUT,
	input wire logic [7:0] ZONE_REM_OUT,
	input wire logic [rlv_pkg::LVL_W-1:0] DISP_LEVEL_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	import rlv_pkg::*;
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (SYS_RST_IN);
	logic [7:0] rem_q_ff;
	logic [31:0] still_ff;
	// Counts how long the remaining time has stood unchanged
	always_ff @(posedge CLK_SYS_IN) begin
		rem_q_ff <= ZONE_REM_OUT;
		if (SYS_RST_IN || ZONE_OUT != ZN_TWO_ONE
			|| ZONE_REM_OUT != rem_q_ff) begin
			still_ff <= 32'h0;
		end else begin
			still_ff <= still_ff + 32'h1;
		end
	end
	function automatic logic [6:0] shown(input logic [6:0] l);
		return 7'(l <= 15 ? 50 : l <= 31 ? 60 : l <= 47 ? 70 : l <= 63 ? 80
			: l <= 79 ? 90 : 100);
	endfunction
	led_match_a: assert property (RAISE_LED_OUT == RAISE_OUT
		&& LOWER_LED_OUT == LOWER_OUT) else $error("lamp differs");
	no_overlap_a: assert property (!(RAISE_OUT && LOWER_OUT))
		else $error("raise and lower together");
	disp_map_a: assert property (!$past(SYS_RST_IN) |->
		DISP_LEVEL_OUT == shown($past(LEVEL_IN))) else $error("bad shown level");
	rem_idle_a: assert property (ZONE_OUT != ZN_TWO_ONE |->
		ZONE_REM_OUT == 8'h00) else $error("time left outside transition");
	rem_load_a: assert property ($past(ZONE_OUT) == ZN_TWO
		&& ZONE_OUT == ZN_TWO_ONE |-> ZONE_REM_OUT == 8'h3c)
		else $error("countdown not loaded");
	rem_step_a: assert property (ZONE_OUT == ZN_TWO_ONE
		&& $past(ZONE_OUT) == ZN_TWO_ONE && $changed(ZONE_REM_OUT)
		|-> ZONE_REM_OUT == $past(ZONE_REM_OUT) - 8'h01)
		else $error("countdown step wrong");
	rem_pace_a: assert property (ZONE_OUT == ZN_TWO_ONE |->
		still_ff <= TICK_CYC) else $error("countdown stalled");
	zone_skip_a: assert property ($past(ZONE_OUT) == ZN_TWO |->
		ZONE_OUT != ZN_ONE) else $error("zone 1 without waiting");
	qual_done_a: assert property ($past(ZONE_OUT) == ZN_TWO_ONE
		&& ZONE_OUT == ZN_ONE |-> $past(ZONE_REM_OUT) <= 8'h01)
		else $error("zone 1 too early");
	wr_resp_a: assert property (AWVALID_IN && AWREADY_OUT && WVALID_IN
		&& WREADY_OUT |-> ##2 BVALID_OUT) else $error("no write response");
	rd_resp_a: assert property (ARVALID_IN && ARREADY_OUT |=> RVALID_OUT)
		else $error("no read response");
	zone_back_c: cover property (ZONE_OUT == ZN_TWO_ONE ##1 ZONE_OUT == ZN_ONE);
	raise_c: cover property (RAISE_OUT);
	lower_c: cover property (LOWER_OUT);
endmodule

bind rlv_top rlv_top_asserts #(.TICK_CYC(TICK_CYC)) i_chk (.CLK_SYS_IN,
	.SYS_RST_IN, .AWVALID_IN, .AWREADY_OUT, .WVALID_IN, .WREADY_OUT,
	.BVALID_OUT, .ARVALID_IN, .ARREADY_OUT, .RVALID_OUT, .LEVEL_IN, .RAISE_OUT,
	.LOWER_OUT, .RAISE_LED_OUT, .LOWER_LED_OUT, .ZONE_OUT, .ZONE_REM_OUT,
	.DISP_LEVEL_OUT);

// ===== verification/rlv_valve_model.sv
module rlv_valve_model #(
	parameter int unsigned STEP = 4
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Valve commands
	input wire logic raise_in,
	input wire logic lower_in,
	// Sensor
	input wire logic [6:0] set_lvl_in,
	output logic [6:0] level_out,
	output logic [6:0] pos_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] step_ff;
	// Sensor answers a cycle late, like a filtered transmitter
	always_ff @(posedge clk_in) begin
		level_out <= set_lvl_in;
	end
	// Orifice travels one percent per STEP cycles
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			step_ff <= 8'h0;
			pos_out <= 7'h0;
		end else if (step_ff + 8'h1 >= 8'(STEP)) begin
			step_ff <= 8'h0;
			if (lower_in && pos_out < 7'h64) begin
				pos_out <= pos_out + 7'h1;
			end else if (raise_in && pos_out > 7'h0) begin
				pos_out <= pos_out - 7'h1;
			end
		end else begin
			step_ff <= step_ff + 8'h1;
		end
	end
endmodule

// ===== verification/refrigerant_level_valve_control_test.sv
module refrigerant_level_valve_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	import rlv_pkg::*;
	localparam int TC = 20;
	logic clk, rst, awv, wv, bready, arv, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [6:0] set_lvl, lvl, disp, v;
	logic awr, wr_rdy, bvalid, arr, rvalid, raise, lower, man;
	logic [1:0] bresp, rresp, zone;
	logic [7:0] rem;
	logic [65:0] rq[$];
	logic [1:0] bq[$];
	int failures = 0, n_tests = 0, seed = 32'h33d9ceff;
	logic [6:0] edg[8] = '{0, 15, 16, 47, 48, 79, 80, 100};
	logic [3:0] keys[6] = '{4'h1, 4'h2, 4'h4, 4'h3, 4'h5, 4'h8};
	logic [2:0] kexp[6] = '{3'h3, 3'h5, 3'h1, 3'h3, 3'h1, 3'h0};
	logic [7:0] rin[4] = '{8'h2, 8'h3, 8'hf, 8'h10};
	logic [7:0] rexp[4] = '{8'h3, 8'h3, 8'hf, 8'hf};
	rlv_top #(.TICK_CYC(TC)) i_dut (.CLK_SYS_IN(clk), .SYS_RST_IN(rst),
		.AWADDR_IN(awaddr), .AWVALID_IN(awv), .AWREADY_OUT(awr),
		.WDATA_IN(wdata), .WSTRB_IN(4'hf), .WVALID_IN(wv), .WREADY_OUT(wr_rdy),
		.BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
		.ARADDR_IN(araddr), .ARVALID_IN(arv), .ARREADY_OUT(arr),
		.RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid),
		.RREADY_IN(rready), .LEVEL_IN(lvl), .RAISE_OUT(raise),
		.LOWER_OUT(lower), .RAISE_LED_OUT(), .LOWER_LED_OUT(),
		.MANUAL_OUT(man), .ZONE_OUT(zone), .ZONE_REM_OUT(rem),
		.DISP_LEVEL_OUT(disp));
	rlv_valve_model i_valve (.clk_in(clk), .rst_in(rst), .raise_in(raise),
		.lower_in(lower), .set_lvl_in(set_lvl), .level_out(lvl), .pos_out());
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	function automatic logic [6:0] shown(input logic [6:0] l);
		return 7'(l <= 15 ? 50 : l <= 31 ? 60 : l <= 47 ? 70 : l <= 63 ? 80
			: l <= 79 ? 90 : 100);
	endfunction
	task automatic summarize();
		$display("failures=%0d n_tests=%0d", failures, n_tests);
		if (failures == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk_rd(input logic [65:0] x);
		n_tests++;
		if ((rdata & x[33:2]) !== x[65:34] || rresp !== x[1:0]) begin
			failures++;
			$display("ERROR rdata exp %h/%h got %h/%h", x[65:34], x[1:0],
				rdata & x[33:2], rresp);
		end
	endtask
	task automatic chk_b(input logic [1:0] r);
		n_tests++;
		if (bresp !== r) begin
			failures++;
			$display("ERROR bresp exp %h got %h", r, bresp);
		end
	endtask
	task automatic chk_m(input logic e);
		n_tests++;
		if (man !== e) begin
			failures++;
			$display("ERROR manual exp %b got %b", e, man);
		end
	endtask
	// Results are matched in the order requests were issued
	always @(posedge clk) begin
		if (rvalid && rready && rq.size() > 0) chk_rd(rq.pop_front());
		if (bvalid && bready && bq.size() > 0) chk_b(bq.pop_front());
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		bq.push_back(r);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wr_rdy) wv <= 1'b0;
		end while (!(bready && bvalid));
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
		input logic [1:0] r);
		rq.push_back({e, m, r});
		repeat (2) @(posedge clk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arv && arr) arv <= 1'b0;
		end while (!(rready && rvalid));
		rready <= 1'b0;
	endtask
	task automatic lv(input logic [6:0] x, input int secs);
		@(posedge clk);
		set_lvl <= x;
		repeat (secs * TC) @(posedge clk);
	endtask
	initial begin
		rst = 1'b1;
		{awv, wv, bready, arv, rready} = 5'h0;
		{awaddr, araddr, wdata} = 48'h0;
		set_lvl = 7'd50;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(A_PRESET, 32'd50, 32'h7f, RESP_OKAY);
		rd(A_RAMP, 32'd8, 32'hf, RESP_OKAY);
		rd(A_KEY, 32'h0, 32'hffffffff, RESP_OKAY);
		rd(8'h24, 32'h0, 32'hffffffff, RESP_SLVERR);
		wr(8'h24, 32'h1, RESP_SLVERR);
		for (int i = 0; i < 4; i++) begin
			wr(A_RAMP, {24'h0, rin[i]}, RESP_OKAY);
			rd(A_RAMP, {24'h0, rexp[i]}, 32'hf, RESP_OKAY);
		end
		wr(A_PRESET, 32'h65, RESP_OKAY);
		rd(A_PRESET, 32'h64, 32'h7f, RESP_OKAY);
		for (int i = 0; i < 20; i++) begin
			v = i < 8 ? edg[i] : 7'($unsigned($random(seed)) % 101);
			lv(v, 0);
			rd(A_STATUS, {1'b0, shown(v), 24'h0}, 32'h7f000000, RESP_OKAY);
		end
		for (int i = 0; i < 6; i++) begin
			wr(A_KEY, {28'h0, keys[i]}, RESP_OKAY);
			rd(A_STATUS, {29'h0, kexp[i]}, 32'h7, RESP_OKAY);
			chk_m(kexp[i][0]);
		end
		wr(A_PRESET, 32'h3, RESP_OKAY);
		wr(A_CTRL, 32'h1, RESP_OKAY);
		repeat (3 * TC / 2) @(posedge clk);
		rd(A_STATUS, 32'ha, 32'he, RESP_OKAY);
		lv(7'd55, 3);
		rd(A_STATUS, 32'h0, 32'he, RESP_OKAY);
		wr(A_CTRL, 32'h2, RESP_OKAY);
		lv(7'd55, 25);
		rd(A_STATUS, 32'h14, 32'h36, RESP_OKAY);
		lv(7'd70, 12);
		rd(A_STATUS, 32'h24, 32'h36, RESP_OKAY);
		lv(7'd45, 30);
		rd(A_STATUS, 32'h32, 32'h36, RESP_OKAY);
		lv(7'd70, 3);
		rd(A_STATUS, 32'h20, 32'h30, RESP_OKAY);
		lv(7'd45, 62);
		rd(A_STATUS, 32'h10, 32'h30, RESP_OKAY);
		wr(A_CTRL, 32'h0, RESP_OKAY);
		rd(A_STATUS, 32'h0, 32'h30, RESP_OKAY);
		// Second reset after run is cleared, then a fresh start below setpoint
		rst <= 1'b1;
		lv(7'd40, 0);
		rst <= 1'b0;
		wr(A_CTRL, 32'h2, RESP_OKAY);
		lv(7'd40, 182);
		rd(A_STATUS, 32'h280040, 32'h7f0040, RESP_OKAY);
		summarize();
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		summarize();
	end
endmodule
